// ==== src/uft_params.svh ====
// offsets, field positions, reset values and divisor counts of the frame transmitter
// assumes inclusion by the package, by the transmitter module and by the bench
`ifndef UFT_PARAMS_SVH
`define UFT_PARAMS_SVH

// register byte offsets
`define UFT_OFS_DATA 8'h00
`define UFT_OFS_CTRL_B 8'h04
`define UFT_OFS_CTRL_C 8'h08
`define UFT_OFS_STATUS 8'h0c
`define UFT_OFS_BAUD 8'h10

// ctrl_status_b fields
`define UFT_B_TX_EN 0
`define UFT_B_NINTH 1

// ctrl_status_c fields
`define UFT_C_SIZE_LO 0
`define UFT_C_PAR_LO 3
`define UFT_C_STOP2 5
`define UFT_C_SYNC 6
`define UFT_C_POL 7
`define UFT_C_MASTER 8

// status fields
`define UFT_S_EMPTY 0
`define UFT_S_TXC 1
`define UFT_S_U2X 2

// reset values
`define UFT_RST_CTRL_B 2'h0
`define UFT_RST_CTRL_C 9'h006
`define UFT_RST_BAUD 12'h000

// transmitter divisors of the baud generator output
`define UFT_DIV_NORMAL 5'h10
`define UFT_DIV_DOUBLE 5'h08
`define UFT_DIV_SYNC 5'h02

// character size code of nine-bit characters
`define UFT_SIZE_NINE 3'h7

`endif

// ==== src/uft_pkg.sv ====
// types shared by the frame transmitter
// assumes uft_params.svh is on the include path
`include "uft_params.svh"

package uft_pkg;

    // frame format, common to transmitter and receiver
    typedef struct packed {
        logic [2:0] char_size_sel;
        logic [1:0] parity_mode_sel;
        logic stop_count_sel;
    } uft_fmt_s;

    // clocking mode
    typedef struct packed {
        logic sync_mode;
        logic clock_master;
        logic clock_polarity_bit;
        logic double_speed_bit;
    } uft_clk_s;

    typedef enum logic [2:0] {
        UFT_IDLE,
        UFT_START,
        UFT_DATA,
        UFT_PARITY,
        UFT_STOP1,
        UFT_STOP2
    } uft_state_e;

endpackage : uft_pkg

// ==== src/uft_transmitter.sv ====
// frame transmitter: AHB-Lite register slave, baud generator, one-level buffer, shift register
// assumes one clock clk_in at 10 MHz, synchronous reset, and a receiver fed from fmt_out
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "uft_params.svh"

module uft_transmitter
    import uft_pkg::*;
#(
    parameter int BAUD_W = 12
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_out,
    input wire logic transfer_clock_pin_in,
    output logic transfer_clock_pin_out,
    output logic transfer_clock_pin_oe_out,
    output uft_fmt_s fmt_out
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // data bit count from the size code; reserved codes act as eight
    function automatic logic [3:0] data_bits(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h8;
        if (code == `UFT_SIZE_NINE) begin
            n = 4'h9;
        end else if (code < 3'h4) begin
            n = {2'h1, code[1:0]} + 4'h1;
        end
        return n;
    endfunction : data_bits

    // keep only the bits that belong to the character
    function automatic logic [8:0] char_mask(input logic [2:0] code);
        return 9'h1ff >> (4'h9 - data_bits(code));
    endfunction : char_mask

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [1:0] ctrl_b_ff;
    logic [8:0] ctrl_c_ff;
    logic u2x_ff;
    logic [BAUD_W-1:0] baud_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic buf_full_ff;
    logic [8:0] buf_ff;
    logic txc_ff;
    logic busy_ff;

    wire addr_take = ce_in & hsel_in & htrans_in[1] & hready_in;
    wire [7:0] addr_lo = {haddr_in[7:2], 2'h0};
    wire wr_act = ce_in & wr_pend_ff;
    wire wr_data = wr_act & (wr_addr_ff == `UFT_OFS_DATA);
    wire wr_ctrl_b = wr_act & (wr_addr_ff == `UFT_OFS_CTRL_B);
    wire wr_ctrl_c = wr_act & (wr_addr_ff == `UFT_OFS_CTRL_C);
    wire wr_status = wr_act & (wr_addr_ff == `UFT_OFS_STATUS);
    wire wr_baud = wr_act & (wr_addr_ff == `UFT_OFS_BAUD);
    wire tx_empty = ~buf_full_ff;

    // read mux, sampled in the address phase; unmapped reads give zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (addr_lo)
            `UFT_OFS_CTRL_B: rd_mux = {30'h0, ctrl_b_ff};
            `UFT_OFS_CTRL_C: rd_mux = {23'h0, ctrl_c_ff};
            `UFT_OFS_STATUS: rd_mux = {29'h0, u2x_ff, txc_ff, tx_empty};
            `UFT_OFS_BAUD: rd_mux = {{(32-BAUD_W){1'b0}}, baud_ff};
            default: rd_mux = 32'h0;
        endcase
    end

    assign hreadyout_out = ce_in; // zero wait states while running
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_ff;

    // address phase capture and configuration writes
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h0;
            hrdata_ff <= 32'h0;
            ctrl_b_ff <= `UFT_RST_CTRL_B;
            ctrl_c_ff <= `UFT_RST_CTRL_C;
            u2x_ff <= 1'b0;
            baud_ff <= `UFT_RST_BAUD;
        end else if (ce_in) begin
            wr_pend_ff <= addr_take & hwrite_in;
            wr_addr_ff <= addr_lo;
            if (addr_take & ~hwrite_in) begin
                hrdata_ff <= rd_mux;
            end
            if (wr_ctrl_b) begin
                ctrl_b_ff <= hwdata_in[1:0];
            end
            if (wr_ctrl_c) begin
                ctrl_c_ff <= hwdata_in[8:0];
            end
            if (wr_status) begin
                u2x_ff <= hwdata_in[`UFT_S_U2X];
            end
            if (wr_baud) begin
                baud_ff <= hwdata_in[BAUD_W-1:0];
            end
        end
    end

    // format and clock fields
    uft_fmt_s fmt;
    uft_clk_s clkm;
    assign fmt.char_size_sel = ctrl_c_ff[`UFT_C_SIZE_LO +: 3];
    assign fmt.parity_mode_sel = ctrl_c_ff[`UFT_C_PAR_LO +: 2];
    assign fmt.stop_count_sel = ctrl_c_ff[`UFT_C_STOP2];
    assign clkm.sync_mode = ctrl_c_ff[`UFT_C_SYNC];
    assign clkm.clock_master = ctrl_c_ff[`UFT_C_MASTER];
    assign clkm.clock_polarity_bit = ctrl_c_ff[`UFT_C_POL];
    assign clkm.double_speed_bit = u2x_ff & ~ctrl_c_ff[`UFT_C_SYNC];
    // receiver takes the very same setting; it checks only the first stop bit
    assign fmt_out = fmt;
    wire tx_enable_bit = ctrl_b_ff[`UFT_B_TX_EN];
    wire par_en = fmt.parity_mode_sel[1];

    // ------------------------------------------------------------
    // baud generator and bit timing
    // ------------------------------------------------------------
    logic [BAUD_W-1:0] bcnt_ff;
    logic [4:0] div_ff;
    logic phase_ff;
    logic [2:0] xck_sync_ff;
    logic xck_lvl_ff;

    wire baud_tick = ce_in & (bcnt_ff == '0);
    wire [4:0] div_sel = clkm.double_speed_bit ? `UFT_DIV_DOUBLE : `UFT_DIV_NORMAL;
    // compare by range so a switch from 16 to 8 cannot strand the divider above its end point
    wire async_tick = baud_tick & (div_ff >= div_sel - 5'h1);
    wire master_tick = baud_tick & ~phase_ff;
    wire xck_agree = xck_sync_ff[1] == xck_sync_ff[2];
    wire xck_change = ce_in & xck_agree & (xck_sync_ff[1] != xck_lvl_ff);
    // change edge is rising for polarity zero, falling for one
    wire slave_tick = xck_change & (xck_sync_ff[1] ^ clkm.clock_polarity_bit);
    wire sync_tick = clkm.clock_master ? master_tick : slave_tick;
    wire bit_tick = clkm.sync_mode ? sync_tick : async_tick;

    // down-counter reloads on zero or on a divisor write
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bcnt_ff <= '0;
            div_ff <= 5'h0;
            phase_ff <= 1'b0;
        end else if (ce_in) begin
            bcnt_ff <= wr_baud ? hwdata_in[BAUD_W-1:0] : (baud_tick ? baud_ff : bcnt_ff - 1'b1);
            if (baud_tick) begin
                div_ff <= async_tick ? 5'h0 : div_ff + 5'h1;
                phase_ff <= ~phase_ff;
            end
        end
    end

    // external transfer clock: three stages, level accepted when two agree
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            xck_sync_ff <= 3'h0;
            xck_lvl_ff <= 1'b0;
        end else if (ce_in) begin
            xck_sync_ff <= {xck_sync_ff[1:0], transfer_clock_pin_in};
            if (xck_agree) begin
                xck_lvl_ff <= xck_sync_ff[1];
            end
        end
    end

    // master drives the pin; data changes as phase rises
    assign transfer_clock_pin_out = phase_ff ^ clkm.clock_polarity_bit;
    assign transfer_clock_pin_oe_out = clkm.sync_mode & clkm.clock_master;

    // ------------------------------------------------------------
    // transmit buffer and shift register
    // ------------------------------------------------------------
    uft_state_e state_ff;
    uft_state_e nxt_state;
    logic [8:0] shift_ff;
    logic [3:0] cnt_ff;
    logic par_ff;
    logic txd_ff;

    wire tx_active = tx_enable_bit | busy_ff | buf_full_ff;
    wire last_data = cnt_ff == data_bits(fmt.char_size_sel) - 4'h1;
    wire frame_end = bit_tick & (((state_ff == UFT_STOP1) & ~fmt.stop_count_sel) | (state_ff == UFT_STOP2));
    // load when idle, or right at the end of the last stop bit
    wire load = bit_tick & buf_full_ff & tx_active & ((state_ff == UFT_IDLE) | frame_end);
    wire [8:0] buf_char = buf_ff & char_mask(fmt.char_size_sel);
    wire par_calc = ^buf_char ^ fmt.parity_mode_sel[0];

    // state sequencing on bit ticks
    always_comb begin
        nxt_state = state_ff;
        if (load) begin
            nxt_state = UFT_START;
        end else if (bit_tick) begin
            unique case (state_ff)
                UFT_IDLE: nxt_state = UFT_IDLE;
                UFT_START: nxt_state = UFT_DATA;
                UFT_DATA: nxt_state = last_data ? (par_en ? UFT_PARITY : UFT_STOP1) : UFT_DATA;
                UFT_PARITY: nxt_state = UFT_STOP1;
                UFT_STOP1: nxt_state = fmt.stop_count_sel ? UFT_STOP2 : UFT_IDLE;
                UFT_STOP2: nxt_state = UFT_IDLE;
            endcase
        end
    end

    // serial line level for the state being entered
    logic nxt_txd;
    always_comb begin
        nxt_txd = 1'b1;
        unique case (nxt_state)
            UFT_START: nxt_txd = 1'b0;
            UFT_DATA: nxt_txd = (state_ff == UFT_START) ? shift_ff[0] : shift_ff[1];
            UFT_PARITY: nxt_txd = par_ff;
            default: nxt_txd = 1'b1;
        endcase
    end

    // the ninth bit is caught from the control bit at the data write
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            buf_full_ff <= 1'b0;
            buf_ff <= 9'h0;
            txc_ff <= 1'b0;
        end else if (ce_in) begin
            if (wr_data) begin
                buf_ff <= {ctrl_b_ff[`UFT_B_NINTH], hwdata_in[7:0]};
                buf_full_ff <= 1'b1;
            end else if (load) begin
                buf_full_ff <= 1'b0;
            end
            // hardware set wins over a one written to clear
            if (frame_end & ~buf_full_ff) begin
                txc_ff <= 1'b1;
            end else if (wr_status & hwdata_in[`UFT_S_TXC]) begin
                txc_ff <= 1'b0;
            end
        end
    end

    // shift register, data bit counter and line register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_ff <= UFT_IDLE;
            shift_ff <= 9'h0;
            cnt_ff <= 4'h0;
            par_ff <= 1'b0;
            txd_ff <= 1'b1;
            busy_ff <= 1'b0;
        end else if (ce_in) begin
            state_ff <= nxt_state;
            // the line moves only on bit ticks, so every bit stands one full period
            if (bit_tick) begin
                txd_ff <= nxt_txd;
            end
            busy_ff <= nxt_state != UFT_IDLE;
            if (load) begin
                shift_ff <= buf_char;
                par_ff <= par_calc;
                cnt_ff <= 4'h0;
            end else if (bit_tick & (state_ff == UFT_DATA)) begin
                shift_ff <= shift_ff >> 1;
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

    // pin handed over while enabled or until pending data has gone
    assign serial_out_pin_out = txd_ff;
    assign serial_out_pin_oe_out = tx_active;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_start_low: assert property (@(posedge clk_in) disable iff (srst_in)
        (state_ff == UFT_START) |-> !txd_ff) else $error("start bit not low");
    a_stop_high: assert property (@(posedge clk_in) disable iff (srst_in)
        (state_ff == UFT_STOP1 || state_ff == UFT_STOP2) |-> txd_ff) else $error("stop bit not high");
    a_idle_high: assert property (@(posedge clk_in) disable iff (srst_in)
        (state_ff == UFT_IDLE && tx_enable_bit) |-> serial_out_pin_out && serial_out_pin_oe_out)
        else $error("idle line not high");
    a_lsb_first: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && bit_tick && state_ff == UFT_DATA && !last_data) |=> txd_ff == $past(shift_ff[1]))
        else $error("data bit order wrong");
    a_parity_bit: assert property (@(posedge clk_in) disable iff (srst_in)
        (state_ff == UFT_PARITY) |-> txd_ff == par_ff) else $error("parity bit wrong");
    a_buffer_empty: assert property (@(posedge clk_in) disable iff (srst_in)
        wr_data |=> !tx_empty) else $error("buffer empty after write");
    a_txc_set: assert property (@(posedge clk_in) disable iff (srst_in)
        (frame_end && !buf_full_ff) |=> txc_ff) else $error("complete flag not set");
    a_buffer_move: assert property (@(posedge clk_in) disable iff (srst_in)
        (load && !wr_data) |=> state_ff == UFT_START && tx_empty) else $error("buffer not moved");
    a_pin_enable: assert property (@(posedge clk_in) disable iff (srst_in)
        tx_enable_bit |-> serial_out_pin_oe_out) else $error("pin not taken");
    a_stop_count: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && bit_tick && state_ff == UFT_STOP1 && fmt.stop_count_sel && !load) |=> state_ff == UFT_STOP2)
        else $error("second stop bit missing");

endmodule : uft_transmitter

// ==== testbench/uft_remote_rx.sv ====
// remote serial receiver model: decodes each frame seen on the serial line
// assumes the line idles high and the bench gives the bit period in clocks
`timescale 1ns/1ns

module uft_remote_rx
    import uft_pkg::*;
(
    input wire logic clk_in,
    input wire logic line_in,
    input wire uft_fmt_s fmt_in,
    input wire logic [15:0] bit_clks_in,
    output logic [12:0] frame_out,
    output logic [7:0] count_out,
    output logic [31:0] start_t_out,
    output logic [31:0] prev_t_out,
    output logic frame_err_out,
    input wire logic xck_run_in,
    output logic xck_out
);
    logic [15:0] half_cnt = 16'h0;
    logic xck_ff = 1'b0;
    int n;
    int nb;

    // far-side transfer clock for synchronous slave tests; stands still while not running
    assign xck_out = xck_ff;
    always @(posedge clk_in) begin
        if (!xck_run_in) begin
            half_cnt <= 16'h0;
        end else if (half_cnt == bit_clks_in / 2 - 1) begin
            half_cnt <= 16'h0;
            xck_ff <= ~xck_ff;
        end else begin
            half_cnt <= half_cnt + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // frame capture, sampled mid-bit, start bit in bit 0
    // ------------------------------------------------------------
    initial begin
        {frame_out, count_out, start_t_out, prev_t_out, frame_err_out} = '0;
        forever begin
            @(negedge line_in);
            prev_t_out = start_t_out;
            start_t_out = 32'($time / 100); // clock cycles of 100 ns
            // same format setting as the transmitter
            n = fmt_in.char_size_sel == 3'h7 ? 9 : (fmt_in.char_size_sel > 3'h3 ? 8 : fmt_in.char_size_sel + 5);
            nb = 2 + n + fmt_in.parity_mode_sel[1] + fmt_in.stop_count_sel;
            frame_out = 13'h0;
            repeat (bit_clks_in / 2) @(posedge clk_in);
            for (int i = 0; i < nb; i++) begin
                frame_out[i] = line_in;
                if (i < nb - 1) repeat (bit_clks_in) @(posedge clk_in);
            end
            // only the first stop bit decides a framing fault
            frame_err_out = !frame_out[nb - 1 - fmt_in.stop_count_sel];
            count_out = count_out + 1;
        end
    end
endmodule : uft_remote_rx

// ==== testbench/uft_transmitter_tb.sv ====
// self-checking bench of the frame transmitter over AHB-Lite
// assumes the package, the design and the remote receiver model are compiled first
`timescale 1ns/1ns
`include "uft_params.svh"

module uft_transmitter_tb
    import uft_pkg::*;
();
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready, hresp, ser, ser_oe, xck, xck_oe, ferr;
    logic xck_run = 1'b0;
    logic xck_ext;
    uft_fmt_s fmt;
    logic [15:0] bit_clks = 16'h0010;
    logic [12:0] frame;
    logic [7:0] count;
    logic [31:0] t_new, t_old;
    int errors = 0;
    int tests_run = 0;

    uft_transmitter dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .serial_out_pin_out(ser),
        .serial_out_pin_oe_out(ser_oe), .transfer_clock_pin_in(xck_ext), .transfer_clock_pin_out(xck),
        .transfer_clock_pin_oe_out(xck_oe), .fmt_out(fmt));

    uft_remote_rx far_end (.clk_in(clk_in), .line_in(ser), .fmt_in(fmt), .bit_clks_in(bit_clks),
        .frame_out(frame), .count_out(count), .start_t_out(t_new), .prev_t_out(t_old), .frame_err_out(ferr),
        .xck_run_in(xck_run), .xck_out(xck_ext));

    // 10 MHz clock
    initial forever #50 clk_in = ~clk_in;

    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        rd = hrdata;
    endtask : ahb

    task automatic wait_stat(input int b, input logic v);
        int k;
        k = 0;
        ahb(1'b0, `UFT_OFS_STATUS, 32'h0);
        while (rd[b] !== v && k < 3000) begin
            ahb(1'b0, `UFT_OFS_STATUS, 32'h0);
            k++;
        end
        chk(rd[b], v, "status flag");
    endtask : wait_stat

    // ninth bit goes in before the low byte, upper written bits set on purpose
    task automatic send(input logic [8:0] d);
        ahb(1'b1, `UFT_OFS_CTRL_B, {30'h0, d[8], 1'b1});
        ahb(1'b1, `UFT_OFS_DATA, {24'hffffff, d[7:0]});
    endtask : send

    task automatic get_frame(input logic [8:0] d, input logic [2:0] code, input logic [1:0] pm, input logic s2);
        logic [7:0] c0;
        logic [12:0] e;
        int n;
        int p;
        int k;
        c0 = count;
        k = 0;
        while (count === c0 && k < 20000) begin
            @(posedge clk_in);
            k++;
        end
        chk(32'(k < 20000), 32'h1, "frame arrived");
        n = code == 3'h7 ? 9 : (code > 3'h3 ? 8 : code + 5);
        e = 13'h0;
        for (int i = 0; i < n; i++) e[1 + i] = d[i];
        if (pm[1]) e[1 + n] = ^(d & ~(9'h1ff << n)) ^ pm[0];
        p = 1 + n + pm[1];
        e[p] = 1'b1;
        if (s2) e[p + 1] = 1'b1;
        chk(frame, e, "frame bits");
        chk(ferr, 1'b0, "first stop bit");
    endtask : get_frame

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_formats();
        logic [2:0] code;
        logic [1:0] pm;
        logic [8:0] d;
        for (int z = 0; z < 5; z++)
            for (int p = 0; p < 3; p++)
                for (int s = 0; s < 2; s++) begin
                    code = z == 4 ? 3'h7 : 3'(z);
                    pm = p == 0 ? 2'h0 : 2'(p + 1);
                    d = 9'h1a5 ^ 9'(z * 40 + p * 6 + s);
                    ahb(1'b1, `UFT_OFS_CTRL_C, {26'h0, 1'(s), pm, code});
                    @(negedge clk_in);
                    chk({26'h0, fmt}, {26'h0, code, pm, 1'(s)}, "shared format");
                    send(d);
                    get_frame(d, code, pm, 1'(s));
                    wait_stat(1, 1'b1);
                    ahb(1'b1, `UFT_OFS_STATUS, 32'h2);
                end
        $display("test formats done");
    endtask : test_formats

    task automatic test_b2b(input logic [11:0] div, input logic dbl, input int per);
        ahb(1'b1, `UFT_OFS_CTRL_C, 32'h3);
        ahb(1'b1, `UFT_OFS_BAUD, {20'h0, div});
        ahb(1'b1, `UFT_OFS_STATUS, {29'h0, dbl, 2'h2});
        bit_clks <= 16'(per);
        send(9'h0c3);
        wait_stat(0, 1'b1);
        send(9'h03c);
        ahb(1'b0, `UFT_OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'h0, "buffer held, not complete");
        get_frame(9'h0c3, 3'h3, 2'h0, 1'b0);
        get_frame(9'h03c, 3'h3, 2'h0, 1'b0);
        chk(t_new - t_old, 32'(10 * per), "frame spacing");
        wait_stat(1, 1'b1);
        chk(ser, 1'b1, "idle level");
        $display("test back to back done");
    endtask : test_b2b

    // master mode first, then the far side drives the transfer clock
    task automatic test_sync();
        ahb(1'b1, `UFT_OFS_BAUD, 32'h2);
        ahb(1'b1, `UFT_OFS_CTRL_C, 32'h143);
        bit_clks <= 16'h0006;
        send(9'h05a);
        @(negedge ser);
        @(negedge clk_in);
        chk(xck, 1'b1, "data change on rising clock out");
        get_frame(9'h05a, 3'h3, 2'h0, 1'b0);
        wait_stat(1, 1'b1);
        ahb(1'b1, `UFT_OFS_STATUS, 32'h2);
        ahb(1'b1, `UFT_OFS_CTRL_C, 32'h043);
        bit_clks <= 16'h0010;
        xck_run <= 1'b1;
        send(9'h0a5);
        @(negedge ser);
        @(negedge clk_in);
        chk(xck_ext, 1'b1, "data change on rising clock in");
        chk(xck_oe, 1'b0, "slave leaves clock pin");
        get_frame(9'h0a5, 3'h3, 2'h0, 1'b0);
        wait_stat(1, 1'b1);
        xck_run <= 1'b0;
        ahb(1'b1, `UFT_OFS_STATUS, 32'h2);
        ahb(1'b1, `UFT_OFS_CTRL_C, 32'h3);
        $display("test synchronous done");
    endtask : test_sync

    task automatic test_regs();
        ahb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        chk(hresp, 1'b0, "response");
        ahb(1'b0, `UFT_OFS_CTRL_B, 32'h0);
        chk(rd, 32'h1, "enable bit");
        chk(ser_oe, 1'b1, "pin owned");
        ahb(1'b1, `UFT_OFS_CTRL_C, 32'h143);
        @(negedge clk_in);
        chk(xck_oe, 1'b1, "clock pin taken");
        ahb(1'b1, `UFT_OFS_CTRL_C, 32'h3);
        ahb(1'b1, `UFT_OFS_CTRL_B, 32'h0);
        @(negedge clk_in);
        chk({xck_oe, ser_oe}, 2'h0, "pins released");
        $display("test registers done");
    endtask : test_regs

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // watchdog: about five times the expected run
    initial begin
        #4000000;
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        @(negedge clk_in);
        chk({ser, ser_oe}, 2'h2, "after reset");
        ahb(1'b1, `UFT_OFS_BAUD, 32'h0);
        test_formats();
        test_b2b(12'h001, 1'b0, 32);
        test_b2b(12'h000, 1'b1, 8);
        test_b2b(12'h002, 1'b0, 48);
        test_sync();
        test_regs();
        wrap_up();
    end
endmodule : uft_transmitter_tb
